// ===== rtl/rtcr_top.sv
/*
 * control-register logic of the second low-dropout regulator: axi4-lite
 * register slave, undervoltage handling with interrupt, hardware control
 * overrides, power-up slot enable and the resulting regulator settings.
 * assumes hardware control/enable and fault inputs are asynchronous pins
 * and the sequencer slot strobe comes from logic on aclk.
 */
// Chosen here: register access over AXI4-Lite.
`default_nettype none
module rtcr_top
   import rtcr_pkg::*;
(
   // clock and reset
   input  wire  logic        aclk,
   input  wire  logic        aresetn,
   // axi4-lite write address and data
   input  wire  logic [17:0] awaddr,
   input  wire  logic        awvalid,
   output logic              awready,
   input  wire  logic [31:0] wdata,
   input  wire  logic [3:0]  wstrb,
   input  wire  logic        wvalid,
   output logic              wready,
   // axi4-lite write response
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  wire  logic        bready,
   // axi4-lite read
   input  wire  logic [17:0] araddr,
   input  wire  logic        arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  wire  logic        rready,
   // hardware pins (asynchronous)
   input  wire  logic        hw_ctrl1,
   input  wire  logic        hw_ctrl2,
   input  wire  logic        hw_en1,
   input  wire  logic        hw_en2,
   input  wire  logic        undervolt_det,
   // power-up sequencer (same clock)
   input  wire  logic        seq_slot_valid,
   input  wire  logic [2:0]  seq_slot_num,
   input  wire  logic        seq_shutdown,
   // regulator settings
   output logic              reg_enable,
   output rtcr_mode_e        reg_mode,
   output logic              reg_lp_variant,
   output logic [4:0]        reg_vsel,
   output logic [11:0]       reg_target_mv,
   output logic              reg_discharge,
   output logic              reg_switch_mode,
   // system
   output logic              device_reset_req,
   output logic              irq
);

   // registers
   logic [15:0] ctrl_q;              // regulator_two_control
   logic [15:0] on_q;                // regulator_two_on_control
   logic [15:0] slp_q;               // sleep voltage holder
   logic [1:0]  stat_q;              // sticky events
   logic [1:0]  mask_q;              // interrupt enables
   // bus state
   logic        aw_full_q;
   logic        w_full_q;
   logic [15:0] aw_idx_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   // pin synchronisers: first stage read only by the second
   logic [4:0]  pin_s1_q;
   logic [4:0]  pin_s2_q;
   logic        uv_prev_q;
   // fault and sequencer state
   logic        shdn_q;              // regulator held off by fault
   logic        seq_on_q;            // enabled by its timeslot
   logic        rst_req_q;
   // output flops
   logic        en_q;
   rtcr_mode_e  mode_q;
   logic        lpv_q;
   logic [4:0]  vsel_q;
   logic [11:0] mv_q;
   logic        dis_q;
   logic        swi_q;

   // field views
   logic [1:0]  act;
   logic [1:0]  src;
   logic [1:0]  hmode;
   logic [2:0]  slot;
   logic        hc1_s, hc2_s, he1_s, he2_s, uv_s;
   logic        uv_rise;
   logic        hwc_act;
   logic        wr_go;
   logic [15:0] wmask;
   logic [1:0]  st_clr;
   logic        en_d;
   rtcr_mode_e  mode_d;
   logic [4:0]  vsel_d;

   assign act   = ctrl_q[RTCR_ACT_LSB +: 2];
   assign src   = ctrl_q[RTCR_SRC_LSB +: 2];
   assign hmode = ctrl_q[RTCR_HMODE_LSB +: 2];
   assign slot  = on_q[RTCR_SLOT_LSB +: 3];
   assign {uv_s, he2_s, he1_s, hc2_s, hc1_s} = pin_s2_q;
   assign uv_rise = uv_s & ~uv_prev_q;

   // two-flop synchronisers for all pins, plus edge memory for the fault
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q  <= 5'h0_0;
         pin_s2_q  <= 5'h0_0;
         uv_prev_q <= 1'b0;
      end else begin
         pin_s1_q  <= {undervolt_det, hw_en2, hw_en1, hw_ctrl2, hw_ctrl1};
         pin_s2_q  <= pin_s1_q;
         uv_prev_q <= uv_s;
      end
   end

   // bus handshakes: one write and one read in flight
   assign awready = ~aw_full_q & ~bvalid_q;
   assign wready  = ~w_full_q & ~bvalid_q;
   assign arready = ~rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign wr_go   = aw_full_q & w_full_q & ~bvalid_q;
   // only the two low byte lanes reach 16-bit registers
   assign wmask   = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   // address and data may arrive in either order; hold each until both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         aw_idx_q  <= 16'h0000;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RTCR_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            aw_idx_q  <= awaddr[17:2];
         end else if (wr_go) begin
            aw_full_q <= 1'b0;
         end
         if (wvalid && wready) begin
            w_full_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end else if (wr_go) begin
            w_full_q <= 1'b0;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            // unmapped and read-only targets answer with an error
            unique case (aw_idx_q)
               RTCR_IDX_CTRL, RTCR_IDX_ON, RTCR_IDX_SLEEP,
               RTCR_IDX_STAT, RTCR_IDX_MASK: bresp_q <= RTCR_OKAY;
               default:                      bresp_q <= RTCR_SLVERR;
            endcase
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // configuration registers, reset to their listed defaults
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= RTCR_CTRL_RST;
         on_q   <= RTCR_ON_RST;
         slp_q  <= RTCR_SLP_RST;
         mask_q <= RTCR_ST_RST;
      end else if (wr_go) begin
         unique case (aw_idx_q)
            RTCR_IDX_CTRL:
               ctrl_q <= (ctrl_q & ~(wmask & RTCR_CTRL_WM))
                       | (w_data_q[15:0] & wmask & RTCR_CTRL_WM);
            RTCR_IDX_ON:
               on_q <= (on_q & ~(wmask & RTCR_ON_WM))
                     | (w_data_q[15:0] & wmask & RTCR_ON_WM);
            RTCR_IDX_SLEEP:
               slp_q <= (slp_q & ~(wmask & RTCR_SLP_WM))
                      | (w_data_q[15:0] & wmask & RTCR_SLP_WM);
            RTCR_IDX_MASK:
               if (w_strb_q[0]) mask_q <= w_data_q[1:0];
            default: ;
         endcase
      end
   end

   // read path; the state word shows the live regulator settings
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RTCR_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RTCR_OKAY;
         unique case (araddr[17:2])
            RTCR_IDX_CTRL:  rdata_q <= {16'h0000, ctrl_q};
            RTCR_IDX_ON:    rdata_q <= {16'h0000, on_q};
            RTCR_IDX_SLEEP: rdata_q <= {16'h0000, slp_q};
            RTCR_IDX_STAT:  rdata_q <= {30'h0000_0000, stat_q};
            RTCR_IDX_MASK:  rdata_q <= {30'h0000_0000, mask_q};
            RTCR_IDX_STATE:
               rdata_q <= {16'h0000, 1'b0, shdn_q, seq_on_q, hwc_act,
                           en_q, mode_q, lpv_q, dis_q, swi_q, 1'b0, vsel_q};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= RTCR_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // write-one-to-clear; a new event in the same cycle wins
   assign st_clr = (wr_go && aw_idx_q == RTCR_IDX_STAT && w_strb_q[0])
                   ? w_data_q[1:0] : 2'h0;

   // sticky status and fault reaction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q    <= RTCR_ST_RST;
         shdn_q    <= 1'b0;
         rst_req_q <= 1'b0;
      end else begin
         // interrupt whatever the action, ignore included
         stat_q[RTCR_ST_UV] <= uv_rise | (stat_q[RTCR_ST_UV]
                               & ~st_clr[RTCR_ST_UV]);
         stat_q[RTCR_ST_SHDN] <= (uv_rise && act == RTCR_ACT_SHDN)
                                 | (stat_q[RTCR_ST_SHDN] & ~st_clr[RTCR_ST_SHDN]);
         // the fault shutdown holds until software clears its flag
         if (uv_rise && act == RTCR_ACT_SHDN) begin
            shdn_q <= 1'b1;
         end else if (st_clr[RTCR_ST_SHDN]) begin
            shdn_q <= 1'b0;
         end
         // reserved code 11 is treated like ignore
         rst_req_q <= uv_rise && act == RTCR_ACT_RST;
      end
   end
   assign device_reset_req = rst_req_q;
   assign irq = |(stat_q & mask_q);

   // timed enable latches at the matching sequencer slot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_on_q <= 1'b0;
      end else if (seq_shutdown) begin
         seq_on_q <= 1'b0;
      end else if (seq_slot_valid && seq_slot_num == slot
                   && slot != RTCR_SLOT_NONE && slot <= RTCR_SLOT_LAST) begin
         seq_on_q <= 1'b1;
      end
   end

   // selected hardware control input; deassert returns to on settings
   always_comb begin
      unique case (src)
         RTCR_SRC_ONE: hwc_act = hc1_s;
         RTCR_SRC_TWO: hwc_act = hc2_s;
         RTCR_SRC_ANY: hwc_act = hc1_s | hc2_s;
         default:      hwc_act = 1'b0;
      endcase
   end

   // effective enable, mode and voltage code
   always_comb begin
      unique case (slot)
         RTCR_SLOT_NONE: en_d = 1'b0;
         RTCR_SLOT_HE1:  en_d = he1_s;
         RTCR_SLOT_HE2:  en_d = he2_s;
         default:        en_d = seq_on_q;
      endcase
      if (shdn_q || (hwc_act && hmode == RTCR_HM_OFF)) begin
         en_d = 1'b0;
      end
      if (hwc_act && hmode != RTCR_HM_ONM) begin
         mode_d = RTCR_LOWPWR;
      end else if (on_q[RTCR_ONM_BIT]) begin
         mode_d = RTCR_LOWPWR;
      end else begin
         mode_d = RTCR_NORMAL;
      end
      if (!en_d) begin
         mode_d = RTCR_OFF;
      end
      vsel_d = (hwc_act && ctrl_q[RTCR_VPICK_BIT])
               ? slp_q[RTCR_VSEL_LSB +: 5] : on_q[RTCR_VSEL_LSB +: 5];
   end

   // registered regulator settings
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q   <= 1'b0;
         mode_q <= RTCR_OFF;
         lpv_q  <= 1'b0;
         vsel_q <= 5'h00;
         mv_q   <= RTCR_MV_LO;
         dis_q  <= 1'b1;
         swi_q  <= 1'b0;
      end else begin
         en_q   <= en_d;
         mode_q <= mode_d;
         lpv_q  <= ctrl_q[RTCR_LPV_BIT];
         vsel_q <= vsel_d;
         // linear low range, then coarse high range
         if (vsel_d <= RTCR_VLO_MAX) begin
            mv_q <= RTCR_MV_LO + 12'(vsel_d) * RTCR_STEP_LO;
         end else begin
            mv_q <= RTCR_MV_HI + 12'(vsel_d - RTCR_VHI_MIN) * RTCR_STEP_HI;
         end
         dis_q  <= ~en_d & ~ctrl_q[RTCR_FLT_BIT];
         swi_q  <= ctrl_q[RTCR_SWI_BIT];
      end
   end
   assign reg_enable      = en_q;
   assign reg_mode        = mode_q;
   assign reg_lp_variant  = lpv_q;
   assign reg_vsel        = vsel_q;
   assign reg_target_mv   = mv_q;
   assign reg_discharge   = dis_q;
   assign reg_switch_mode = swi_q;

   // checks
   chk_uv_irq_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      uv_rise |=> stat_q[RTCR_ST_UV]) else $error("undervoltage flag not set");
   chk_uv_reset_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      uv_rise && act == RTCR_ACT_RST |=> device_reset_req ##1 !device_reset_req)
      else $error("reset request wrong");
   chk_uv_shut_off: assert property (@(posedge aclk) disable iff (!aresetn)
      uv_rise && act == RTCR_ACT_SHDN |=> ##1 !reg_enable)
      else $error("regulator not shut down");
   chk_hwc_off_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      hwc_act && hmode == RTCR_HM_OFF |=> reg_mode == RTCR_OFF)
      else $error("hardware off ignored");
   chk_vsel_sleep_pick: assert property (@(posedge aclk) disable iff (!aresetn)
      hwc_act && ctrl_q[RTCR_VPICK_BIT] |=> reg_vsel == $past(slp_q[4:0]))
      else $error("sleep voltage not picked");
   chk_src_none: assert property (@(posedge aclk) disable iff (!aresetn)
      src == 2'h0 |=> reg_vsel == $past(on_q[4:0]))
      else $error("override without source");
   chk_onmode_lp: assert property (@(posedge aclk) disable iff (!aresetn)
      !hwc_act && en_d && on_q[RTCR_ONM_BIT] |=> reg_mode == RTCR_LOWPWR)
      else $error("on mode not applied");
   chk_slot_hw_en: assert property (@(posedge aclk) disable iff (!aresetn)
      slot == RTCR_SLOT_HE1 && !shdn_q && !hwc_act |=> reg_enable == $past(he1_s))
      else $error("hardware enable ignored");
   chk_slot_never: assert property (@(posedge aclk) disable iff (!aresetn)
      slot == RTCR_SLOT_NONE |=> !reg_enable) else $error("enabled at slot 0");
   chk_discharge_off: assert property (@(posedge aclk) disable iff (!aresetn)
      !reg_enable && !$past(ctrl_q[RTCR_FLT_BIT]) |-> reg_discharge)
      else $error("no discharge when off");
   chk_volt_points: assert property (@(posedge aclk) disable iff (!aresetn)
      reg_vsel == 5'h1F |-> reg_target_mv == 12'hCE4) else $error("bad 3.3V point");
   chk_lp_variant: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 reg_lp_variant == $past(ctrl_q[RTCR_LPV_BIT])) else $error("variant lost");

endmodule : rtcr_top
`default_nettype wire

// ===== rtl/rtcr_pkg.sv
/*
 * constants for the second regulator's control registers: register
 * indices, field positions, reset values, codes and voltage steps.
 * assumes a 32-bit axi4-lite register port; byte address = index * 4.
 */
`default_nettype none
package rtcr_pkg;
   // register indices (byte address is four times the index)
   localparam logic [15:0] RTCR_IDX_CTRL  = 16'h406B;
   localparam logic [15:0] RTCR_IDX_ON    = 16'h406C;
   localparam logic [15:0] RTCR_IDX_SLEEP = 16'h406D;
   localparam logic [15:0] RTCR_IDX_STAT  = 16'h4070;
   localparam logic [15:0] RTCR_IDX_MASK  = 16'h4071;
   localparam logic [15:0] RTCR_IDX_STATE = 16'h4072;
   // control register fields
   localparam int RTCR_ACT_LSB   = 14;
   localparam int RTCR_SRC_LSB   = 11;
   localparam int RTCR_VPICK_BIT = 10;
   localparam int RTCR_HMODE_LSB = 8;
   localparam int RTCR_FLT_BIT   = 7;
   localparam int RTCR_SWI_BIT   = 6;
   localparam int RTCR_LPV_BIT   = 0;
   // on-control and sleep fields
   localparam int RTCR_SLOT_LSB  = 13;
   localparam int RTCR_ONM_BIT   = 8;
   localparam int RTCR_VSEL_LSB  = 0;
   // reset values and writable bits
   localparam logic [15:0] RTCR_CTRL_RST = 16'h0200;
   localparam logic [15:0] RTCR_ON_RST   = 16'h0000;
   localparam logic [15:0] RTCR_SLP_RST  = 16'h0000;
   localparam logic [15:0] RTCR_CTRL_WM  = 16'hDFC1;
   localparam logic [15:0] RTCR_ON_WM    = 16'hE11F;
   localparam logic [15:0] RTCR_SLP_WM   = 16'h001F;
   localparam logic [1:0]  RTCR_ST_RST   = 2'h0;
   // status bits: undervoltage seen, regulator shut down by fault
   localparam int RTCR_ST_UV   = 0;
   localparam int RTCR_ST_SHDN = 1;
   // field codes
   localparam logic [1:0] RTCR_ACT_SHDN = 2'h1;
   localparam logic [1:0] RTCR_ACT_RST  = 2'h2;
   localparam logic [1:0] RTCR_SRC_ONE  = 2'h1;
   localparam logic [1:0] RTCR_SRC_TWO  = 2'h2;
   localparam logic [1:0] RTCR_SRC_ANY  = 2'h3;
   localparam logic [1:0] RTCR_HM_OFF   = 2'h1;
   localparam logic [1:0] RTCR_HM_ONM   = 2'h3;
   localparam logic [2:0] RTCR_SLOT_NONE = 3'h0;
   localparam logic [2:0] RTCR_SLOT_LAST = 3'h5;
   localparam logic [2:0] RTCR_SLOT_HE1  = 3'h6;
   localparam logic [2:0] RTCR_SLOT_HE2  = 3'h7;
   // voltage code to millivolts
   localparam logic [4:0]  RTCR_VLO_MAX  = 5'h0E;
   localparam logic [4:0]  RTCR_VHI_MIN  = 5'h0F;
   localparam logic [11:0] RTCR_MV_LO    = 12'h384;
   localparam logic [11:0] RTCR_STEP_LO  = 12'h032;
   localparam logic [11:0] RTCR_MV_HI    = 12'h6A4;
   localparam logic [11:0] RTCR_STEP_HI  = 12'h064;
   // bus answers
   localparam logic [1:0] RTCR_OKAY   = 2'h0;
   localparam logic [1:0] RTCR_SLVERR = 2'h2;
   // regulator operating mode
   typedef enum logic [1:0] {RTCR_NORMAL, RTCR_LOWPWR, RTCR_OFF} rtcr_mode_e;
endpackage : rtcr_pkg
`default_nettype wire

// ===== tb/rtcr_sys_model.sv
/*
 * system-side model of the second regulator's control pins: hardware
 * controls, hardware enables, undervoltage sense and sequencer slots.
 * assumes the bench calls its tasks just after a rising edge of aclk.
 */
`default_nettype none
module rtcr_sys_model (
   // clock
   input  wire logic       aclk,
   // pins toward the regulator block
   output logic            hw_ctrl1,
   output logic            hw_ctrl2,
   output logic            hw_en1,
   output logic            hw_en2,
   output logic            undervolt_det,
   output logic            seq_slot_valid,
   output logic [2:0]      seq_slot_num,
   output logic            seq_shutdown
);
   timeunit 1ns;
   timeprecision 1ns;
   // all pins idle at time zero
   initial begin
      {hw_ctrl1, hw_ctrl2, hw_en1, hw_en2, undervolt_det} = 5'h00;
      {seq_slot_valid, seq_slot_num, seq_shutdown} = 5'h00;
   end
   // level pins change together, held until the next call
   task automatic pins(input logic c1, c2, e1, e2);
      @(posedge aclk);
      {hw_ctrl1, hw_ctrl2, hw_en1, hw_en2} <= {c1, c2, e1, e2};
   endtask : pins
   // one-cycle slot strobe; number is scrambled after so it is never reused
   task automatic slot(input logic [2:0] n);
      @(posedge aclk);
      seq_slot_num   <= n;
      seq_slot_valid <= 1'b1;
      @(posedge aclk);
      seq_slot_valid <= 1'b0;
      seq_slot_num   <= ~n;
   endtask : slot
   // sequencer shutdown pulse
   task automatic shut();
      @(posedge aclk);
      seq_shutdown <= 1'b1;
      @(posedge aclk);
      seq_shutdown <= 1'b0;
   endtask : shut
   // undervoltage held long enough to pass the two-flop synchroniser
   task automatic uv();
      @(posedge aclk);
      undervolt_det <= 1'b1;
      repeat (4) @(posedge aclk);
      undervolt_det <= 1'b0;
   endtask : uv
endmodule : rtcr_sys_model
`default_nettype wire

// ===== tb/regulator_two_control_regs_bench.sv
/*
 * self-checking bench for the regulator control block: axi4-lite tasks,
 * the pin model, and a sequence of register and pin scenarios.
 * assumes the rtcr_pkg constants and the rtcr_top port list.
 */
`default_nettype none
module regulator_two_control_regs_bench import rtcr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // bus side
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [17:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   // pins and settings
   logic        hw_ctrl1, hw_ctrl2, hw_en1, hw_en2, undervolt_det;
   logic        seq_slot_valid, seq_shutdown, reg_enable, reg_lp_variant;
   logic [2:0]  seq_slot_num;
   rtcr_mode_e  reg_mode;
   logic [4:0]  reg_vsel;
   logic [11:0] reg_target_mv;
   logic        reg_discharge, reg_switch_mode, device_reset_req, irq, rst_seen;
   int          n_fail, tests_run;
   rtcr_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .hw_ctrl1, .hw_ctrl2, .hw_en1, .hw_en2,
      .undervolt_det, .seq_slot_valid, .seq_slot_num, .seq_shutdown, .reg_enable,
      .reg_mode, .reg_lp_variant, .reg_vsel, .reg_target_mv, .reg_discharge,
      .reg_switch_mode, .device_reset_req, .irq);
   rtcr_sys_model sys (.aclk, .hw_ctrl1, .hw_ctrl2, .hw_en1, .hw_en2,
      .undervolt_det, .seq_slot_valid, .seq_slot_num, .seq_shutdown);
   // 50 ns clock
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // the reset request is one cycle wide, so latch it for later checks
   always @(posedge aclk) begin
      if (!aresetn) rst_seen <= 1'b0;
      else if (device_reset_req) rst_seen <= 1'b1;
   end
   task automatic chk(input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // handshakes sampled at the falling edge, so no race with the rising one
   task automatic wr(input logic [15:0] idx, input logic [15:0] d);
      logic a, w, b;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata  <= {16'h0000, d};
      {awvalid, wvalid, bready} <= 3'h7;
      forever begin
         @(negedge aclk);
         a = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         rsp = bresp;
         @(posedge aclk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) begin
            bready <= 1'b0;
            break;
         end
      end
   endtask : wr
   task automatic rd(input logic [15:0] idx);
      logic a, v;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      {arvalid, rready} <= 2'h3;
      forever begin
         @(negedge aclk);
         a = arvalid & arready;
         v = rvalid;
         rdv = rdata;
         rsp = rresp;
         @(posedge aclk);
         if (a) arvalid <= 1'b0;
         if (v) begin
            rready <= 1'b0;
            break;
         end
      end
   endtask : rd
   // pin path is two sync edges plus one output edge; six leaves margin
   task automatic settle();
      repeat (6) @(posedge aclk);
      @(negedge aclk);
   endtask : settle
   task automatic print_verdict();
      if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   // hang guard, far above the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      print_verdict();
   end
   initial begin
      static logic [15:0] ix [5] = '{RTCR_IDX_CTRL, RTCR_IDX_ON, RTCR_IDX_SLEEP,
                                     RTCR_IDX_STAT, RTCR_IDX_MASK};
      static logic [4:0]  vc [4] = '{5'h00, 5'h0E, 5'h0F, 5'h1F};
      static rtcr_mode_e  hm [4] = '{RTCR_LOWPWR, RTCR_OFF, RTCR_LOWPWR, RTCR_NORMAL};
      logic [11:0] mv;
      {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = {36'h0_0000_0000, 32'h0000_0000, 4'hF};
      n_fail = 0;
      tests_run = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // register defaults, then settings while nothing is enabled
      foreach (ix[i]) begin
         rd(ix[i]);
         chk(rdv, (i == 0) ? 32'h0000_0200 : 32'h0000_0000);
         chk(rsp, RTCR_OKAY);
      end
      settle();
      chk({reg_mode, reg_enable, reg_discharge, irq}, {RTCR_OFF, 3'h2});
      // unmapped read and write to the read-only state register
      rd(16'h4000);
      chk(rsp, RTCR_SLVERR);
      chk(rdv, 32'h0000_0000);
      wr(RTCR_IDX_STATE, 16'hFFFF);
      chk(rsp, RTCR_SLVERR);
      // both ends of both voltage segments
      foreach (vc[i]) begin
         wr(RTCR_IDX_ON, {11'h000, vc[i]});
         mv = (vc[i] <= RTCR_VLO_MAX) ? RTCR_MV_LO + RTCR_STEP_LO * vc[i]
                                      : RTCR_MV_HI + RTCR_STEP_HI * (vc[i] - RTCR_VHI_MIN);
         settle();
         chk({reg_vsel, reg_target_mv}, {vc[i], mv});
      end
      // timeslot 3 ignores slot 2, enables on slot 3
      wr(RTCR_IDX_ON, 16'h6000);
      chk(rsp, RTCR_OKAY);
      sys.slot(3'h2);
      settle();
      chk(reg_enable, 1'b0);
      sys.slot(3'h3);
      settle();
      chk({reg_enable, reg_mode}, {1'b1, RTCR_NORMAL});
      // state word: enable (bit 11) and timed latch (bit 13) only
      rd(RTCR_IDX_STATE);
      chk(rdv, 32'h0000_2800);
      wr(RTCR_IDX_ON, 16'h6100);
      wr(RTCR_IDX_CTRL, 16'h0201);
      settle();
      chk({reg_mode, reg_lp_variant}, {RTCR_LOWPWR, 1'b1});
      // disabled: discharge unless floating, switch bit passes through
      sys.shut();
      wr(RTCR_IDX_CTRL, 16'h0240);
      settle();
      chk({reg_enable, reg_discharge, reg_switch_mode}, 3'h3);
      wr(RTCR_IDX_CTRL, 16'h0280);
      settle();
      chk({reg_discharge, reg_switch_mode}, 2'h0);
      // hardware enables one and two
      wr(RTCR_IDX_ON, 16'hC000);
      sys.pins(1'b0, 1'b0, 1'b1, 1'b0);
      settle();
      chk(reg_enable, 1'b1);
      sys.pins(1'b0, 1'b0, 1'b0, 1'b0);
      settle();
      chk(reg_enable, 1'b0);
      wr(RTCR_IDX_ON, 16'hE005);
      sys.pins(1'b0, 1'b0, 1'b0, 1'b1);
      settle();
      chk(reg_enable, 1'b1);
      // control one with sleep voltage: every hardware mode code
      wr(RTCR_IDX_SLEEP, 16'h001F);
      sys.pins(1'b1, 1'b0, 1'b0, 1'b1);
      foreach (hm[i]) begin
         wr(RTCR_IDX_CTRL, 16'h0C00 | {6'h00, i[1:0], 8'h00});
         settle();
         chk(reg_mode, hm[i]);
      end
      chk(reg_vsel, 5'h1F);
      // source two ignores control one; either-source takes control one
      wr(RTCR_IDX_CTRL, 16'h1500);
      settle();
      chk({reg_mode, reg_vsel}, {RTCR_NORMAL, 5'h05});
      sys.pins(1'b0, 1'b1, 1'b0, 1'b1);
      settle();
      chk(reg_mode, RTCR_OFF);
      wr(RTCR_IDX_CTRL, 16'h1D00);
      sys.pins(1'b1, 1'b0, 1'b0, 1'b1);
      settle();
      chk(reg_mode, RTCR_OFF);
      sys.pins(1'b0, 1'b0, 1'b0, 1'b1);
      settle();
      chk({reg_mode, reg_vsel}, {RTCR_NORMAL, 5'h05});
      // undervoltage: ignore, shut down, reserved, device reset
      wr(RTCR_IDX_MASK, 16'h0001);
      wr(RTCR_IDX_CTRL, 16'h0200);
      sys.uv();
      settle();
      chk({irq, reg_enable}, 2'h3);
      wr(RTCR_IDX_STAT, 16'h0001);
      settle();
      chk(irq, 1'b0);
      wr(RTCR_IDX_CTRL, 16'h4200);
      sys.uv();
      settle();
      rd(RTCR_IDX_STAT);
      chk(rdv, 32'h0000_0003);
      chk(reg_enable, 1'b0);
      wr(RTCR_IDX_STAT, 16'h0003);
      settle();
      chk(reg_enable, 1'b1);
      wr(RTCR_IDX_CTRL, 16'hC200);
      sys.uv();
      settle();
      chk({irq, reg_enable, rst_seen}, 3'h6);
      wr(RTCR_IDX_CTRL, 16'h8200);
      sys.uv();
      settle();
      chk(rst_seen, 1'b1);
      // masked status must not raise the line
      wr(RTCR_IDX_MASK, 16'h0000);
      settle();
      chk(irq, 1'b0);
      print_verdict();
   end
endmodule : regulator_two_control_regs_bench
`default_nettype wire
